// ---- logic/lau_pkg.sv ----
/*
 * Shared constants, types and helpers of the logical-AND instruction unit.
 * Assumes a byte-wide fetch stream and a data memory with one-cycle read latency.
 */
package lau_pkg;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_REG_MASK  = 8'hf8;
    localparam logic [7:0] OP_REG       = 8'h58;
    localparam logic [7:0] OP_IND_MASK  = 8'hfe;
    localparam logic [7:0] OP_IND       = 8'h56;
    localparam logic [7:0] OP_A_DIR     = 8'h55;
    localparam logic [7:0] OP_A_IMM     = 8'h54;
    localparam logic [7:0] OP_DIR_A     = 8'h52;
    localparam logic [7:0] OP_DIR_IMM   = 8'h53;
    localparam logic [7:0] OP_C_BIT     = 8'h82;
    localparam logic [7:0] OP_C_NBIT    = 8'hb0;

    // ----------------------------------------------------------------
    // Lengths in bytes and machine cycles
    // ----------------------------------------------------------------
    localparam logic [1:0] LEN_ONE      = 2'h1;
    localparam logic [1:0] LEN_TWO      = 2'h2;
    localparam logic [1:0] LEN_THREE    = 2'h3;
    localparam logic [1:0] MC_ONE       = 2'h1;
    localparam logic [1:0] MC_TWO       = 2'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int         CLK_PERIOD_NS = 100;
    localparam int         MC_TIME_NS    = 1200;
    localparam logic [4:0] MC_CLKS       = 5'((MC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [7:0] SFR_BASE      = 8'h80;
    localparam logic [7:0] BIT_IRAM_BASE = 8'h20;
    localparam logic [2:0] PTR_FIELD_LO  = 3'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FORM_NONE,
        FORM_A_REG,
        FORM_A_DIR,
        FORM_A_IND,
        FORM_A_IMM,
        FORM_DIR_A,
        FORM_DIR_IMM,
        FORM_C_BIT,
        FORM_C_NBIT
    } lau_form_t;

    typedef struct packed {
        lau_form_t  form;
        logic [1:0] len;
        logic [1:0] mcyc;
        logic [2:0] sel;
    } lau_dec_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } lau_byte_t;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       sfr;
        logic       latch;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lau_mem_t;

    typedef struct packed {
        logic       acc_we;
        logic [7:0] acc;
        logic       cy_we;
        logic       cy;
    } lau_wb_t;

    // Direct addresses at and above the base hit special function registers
    function automatic logic is_sfr(input logic [7:0] a);
        return a >= SFR_BASE;
    endfunction

endpackage

// ---- logic/lau_decode.sv ----
/*
 * Opcode decoder: form, byte length, machine cycles and register field.
 * Assumes the opcode byte is stable while it is decoded.
 */
module lau_decode (
    // Opcode in
    input  wire logic [7:0]       opcode,
    // Decoded form
    output lau_pkg::lau_dec_t     dec
);

    always_comb begin
        dec      = '{form: lau_pkg::FORM_NONE, len: lau_pkg::LEN_ONE, mcyc: lau_pkg::MC_ONE, sel: opcode[2:0]};
        if ((opcode & lau_pkg::OP_REG_MASK) == lau_pkg::OP_REG) begin
            dec.form = lau_pkg::FORM_A_REG;
        end else if ((opcode & lau_pkg::OP_IND_MASK) == lau_pkg::OP_IND) begin
            dec.form = lau_pkg::FORM_A_IND;
        end else begin
            unique case (opcode)
                lau_pkg::OP_A_DIR: begin
                    dec.form = lau_pkg::FORM_A_DIR;
                    dec.len  = lau_pkg::LEN_TWO;
                end
                lau_pkg::OP_A_IMM: begin
                    dec.form = lau_pkg::FORM_A_IMM;
                    dec.len  = lau_pkg::LEN_TWO;
                end
                lau_pkg::OP_DIR_A: begin
                    dec.form = lau_pkg::FORM_DIR_A;
                    dec.len  = lau_pkg::LEN_TWO;
                end
                lau_pkg::OP_DIR_IMM: begin
                    dec.form = lau_pkg::FORM_DIR_IMM;
                    dec.len  = lau_pkg::LEN_THREE;
                    dec.mcyc = lau_pkg::MC_TWO;
                end
                lau_pkg::OP_C_BIT: begin
                    dec.form = lau_pkg::FORM_C_BIT;
                    dec.len  = lau_pkg::LEN_TWO;
                    dec.mcyc = lau_pkg::MC_TWO;
                end
                lau_pkg::OP_C_NBIT: begin
                    dec.form = lau_pkg::FORM_C_NBIT;
                    dec.len  = lau_pkg::LEN_TWO;
                    dec.mcyc = lau_pkg::MC_TWO;
                end
                default: begin
                    dec.form = lau_pkg::FORM_NONE;
                end
            endcase
        end
    end

endmodule

// ---- logic/lau_alu.sv ----
/*
 * Byte AND, carry AND and bit address mapping.
 * Assumes operands are held stable by the sequencer for the cycle they are used.
 */
module lau_alu (
    // Byte operands
    input  wire logic [7:0] opnd_a,
    input  wire logic [7:0] opnd_b,
    // Bit operation
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_inv,
    input  wire logic       carry_in,
    // Results
    output logic [7:0]      and_byte,
    output logic            carry_out,
    output logic [7:0]      bit_byte_addr
);

    logic src_bit;

    assign and_byte = opnd_a & opnd_b;

    // Low bit addresses live in the bit-addressable RAM area
    assign bit_byte_addr = lau_pkg::is_sfr(bit_addr) ? {bit_addr[7:3], 3'h0}
                                                     : lau_pkg::BIT_IRAM_BASE + {4'h0, bit_addr[6:3]};

    assign src_bit = opnd_a[bit_addr[2:0]] ^ bit_inv;

    assign carry_out = carry_in & src_bit;

endmodule

// ---- logic/lau_unit.sv ----
/*
 * Logical-AND instruction unit: takes opcode and operand bytes from fetch,
 * reads and writes data memory, writes accumulator and carry back.
 * Assumes the memory answers a read one cycle after the request is seen,
 * and the core owns the accumulator, carry and register bank select.
 */
module lau_unit (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Fetch stream
    input  lau_pkg::lau_byte_t    fetch_in,
    output logic                  fetch_ready,
    output logic                  is_ours,
    // Core state
    input  wire logic [7:0]       accumulator_reg,
    input  wire logic             carry_flag,
    input  wire logic [1:0]       bank_sel,
    // Data memory
    output lau_pkg::lau_mem_t     mem_req,
    input  wire logic [7:0]       mem_rdata,
    // Write back and completion
    output lau_pkg::lau_wb_t      wb,
    output logic                  busy,
    output logic                  done
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        S_OPC,
        S_ARG1,
        S_ARG2,
        S_READ,
        S_LAT,
        S_DATA,
        S_HOLD
    } lau_state_t;

    lau_state_t         st_r;
    lau_state_t         st_nxt;
    lau_pkg::lau_dec_t  dec_r;
    lau_pkg::lau_dec_t  dec_nxt;
    lau_pkg::lau_dec_t  dec_now;
    logic [7:0]         arg1_r;
    logic [7:0]         arg1_nxt;
    logic [7:0]         arg2_r;
    logic [7:0]         arg2_nxt;
    logic               ptr_pend_r;
    logic               ptr_pend_nxt;
    logic [7:0]         rd_addr_r;
    logic [7:0]         rd_addr_nxt;
    logic               rd_sfr_r;
    logic               rd_sfr_nxt;
    logic [4:0]         cnt_r;
    logic [4:0]         cnt_nxt;
    logic [4:0]         cnt_goal;
    lau_pkg::lau_mem_t  mem_r;
    lau_pkg::lau_mem_t  mem_nxt;
    lau_pkg::lau_wb_t   wb_r;
    lau_pkg::lau_wb_t   wb_nxt;
    logic               done_r;
    logic               done_nxt;
    logic               take;
    logic               dir_dest;
    logic               bit_form;
    logic [7:0]         alu_a;
    logic [7:0]         alu_b;
    logic [7:0]         and_byte;
    logic               carry_res;
    logic [7:0]         bit_byte_addr;

    // ----------------------------------------------------------------
    // Decode and arithmetic
    // ----------------------------------------------------------------
    lau_decode u_decode (
        .opcode (fetch_in.data),
        .dec    (dec_now)
    );

    lau_alu u_alu (
        .opnd_a        (alu_a),
        .opnd_b        (alu_b),
        .bit_addr      (arg1_r),
        .bit_inv       (dec_r.form == lau_pkg::FORM_C_NBIT),
        .carry_in      (carry_flag),
        .and_byte      (and_byte),
        .carry_out     (carry_res),
        .bit_byte_addr (bit_byte_addr)
    );

    assign dir_dest = (dec_r.form == lau_pkg::FORM_DIR_A) || (dec_r.form == lau_pkg::FORM_DIR_IMM);
    assign bit_form = (dec_r.form == lau_pkg::FORM_C_BIT) || (dec_r.form == lau_pkg::FORM_C_NBIT);

    always_comb begin
        alu_a = mem_rdata;
        alu_b = accumulator_reg;
        unique case (dec_r.form)
            lau_pkg::FORM_A_IMM:   alu_a = arg1_r;
            lau_pkg::FORM_DIR_IMM: alu_b = arg2_r;
            default:               alu_a = mem_rdata;
        endcase
    end

    // ----------------------------------------------------------------
    // Fetch handshake
    // ----------------------------------------------------------------
    // Foreign opcodes are left for the rest of the core
    assign is_ours     = fetch_in.valid && (dec_now.form != lau_pkg::FORM_NONE);
    assign fetch_ready = (st_r == S_OPC) ? is_ours : (st_r == S_ARG1) || (st_r == S_ARG2);
    assign take        = fetch_in.valid && fetch_ready;

    // Clocks to spend in total, counted from the opcode edge
    assign cnt_goal    = (dec_r.mcyc == lau_pkg::MC_TWO) ? 5'(lau_pkg::MC_CLKS << 1) : lau_pkg::MC_CLKS;

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        dec_nxt      = dec_r;
        arg1_nxt     = arg1_r;
        arg2_nxt     = arg2_r;
        ptr_pend_nxt = ptr_pend_r;
        rd_addr_nxt  = rd_addr_r;
        rd_sfr_nxt   = rd_sfr_r;
        cnt_nxt      = (cnt_r != 5'h1f) ? cnt_r + 5'h01 : cnt_r;
        mem_nxt      = '0;
        wb_nxt       = '0;
        done_nxt     = 1'b0;
        unique case (st_r)
            S_OPC: begin
                cnt_nxt = '0;
                if (take) begin
                    dec_nxt      = dec_now;
                    cnt_nxt      = 5'h01;
                    ptr_pend_nxt = 1'b0;
                    rd_sfr_nxt   = 1'b0;
                    unique case (dec_now.form)
                        lau_pkg::FORM_A_REG: begin
                            rd_addr_nxt = {3'h0, bank_sel, dec_now.sel};
                            st_nxt      = S_READ;
                        end
                        lau_pkg::FORM_A_IND: begin
                            rd_addr_nxt  = {3'h0, bank_sel, lau_pkg::PTR_FIELD_LO[2:1], dec_now.sel[0]};
                            ptr_pend_nxt = 1'b1;
                            st_nxt       = S_READ;
                        end
                        default: begin
                            st_nxt = S_ARG1;
                        end
                    endcase
                end
            end
            S_ARG1: begin
                if (take) begin
                    arg1_nxt = fetch_in.data;
                    if (dec_r.form == lau_pkg::FORM_A_IMM) begin
                        st_nxt = S_DATA;
                    end else if (dec_r.form == lau_pkg::FORM_DIR_IMM) begin
                        st_nxt = S_ARG2;
                    end else begin
                        st_nxt = S_READ;
                    end
                end
            end
            S_ARG2: begin
                if (take) begin
                    arg2_nxt = fetch_in.data;
                    st_nxt   = S_READ;
                end
            end
            S_READ: begin
                mem_nxt.rd = 1'b1;
                if (bit_form) begin
                    mem_nxt.addr = bit_byte_addr;
                    mem_nxt.sfr  = lau_pkg::is_sfr(arg1_r);
                end else if (dec_r.form == lau_pkg::FORM_A_REG || dec_r.form == lau_pkg::FORM_A_IND) begin
                    // Indirect reach never lands in the special registers
                    mem_nxt.addr = rd_addr_r;
                    mem_nxt.sfr  = rd_sfr_r;
                end else begin
                    mem_nxt.addr = arg1_r;
                    mem_nxt.sfr  = lau_pkg::is_sfr(arg1_r);
                end
                mem_nxt.latch = dir_dest;
                st_nxt        = S_LAT;
            end
            S_LAT: begin
                st_nxt = S_DATA;
            end
            S_DATA: begin
                if (ptr_pend_r) begin
                    rd_addr_nxt  = mem_rdata;
                    rd_sfr_nxt   = 1'b0;
                    ptr_pend_nxt = 1'b0;
                    st_nxt       = S_READ;
                end else begin
                    st_nxt = S_HOLD;
                    if (dir_dest) begin
                        mem_nxt.wr    = 1'b1;
                        mem_nxt.addr  = arg1_r;
                        mem_nxt.sfr   = lau_pkg::is_sfr(arg1_r);
                        mem_nxt.latch = 1'b1;
                        mem_nxt.wdata = and_byte;
                    end else if (bit_form) begin
                        wb_nxt.cy_we = 1'b1;
                        wb_nxt.cy    = carry_res;
                    end else begin
                        wb_nxt.acc_we = 1'b1;
                        wb_nxt.acc    = and_byte;
                    end
                end
            end
            S_HOLD: begin
                if (cnt_r >= cnt_goal) begin
                    done_nxt = 1'b1;
                    st_nxt   = S_OPC;
                end
            end
            default: begin
                st_nxt = S_OPC;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r       <= S_OPC;
            dec_r      <= '{form: lau_pkg::FORM_NONE, len: lau_pkg::LEN_ONE, mcyc: lau_pkg::MC_ONE, sel: 3'h0};
            arg1_r     <= '0;
            arg2_r     <= '0;
            ptr_pend_r <= 1'b0;
            rd_addr_r  <= '0;
            rd_sfr_r   <= 1'b0;
            cnt_r      <= '0;
        end else begin
            st_r       <= st_nxt;
            dec_r      <= dec_nxt;
            arg1_r     <= arg1_nxt;
            arg2_r     <= arg2_nxt;
            ptr_pend_r <= ptr_pend_nxt;
            rd_addr_r  <= rd_addr_nxt;
            rd_sfr_r   <= rd_sfr_nxt;
            cnt_r      <= cnt_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem_r  <= '0;
            wb_r   <= '0;
            done_r <= 1'b0;
        end else begin
            mem_r  <= mem_nxt;
            wb_r   <= wb_nxt;
            done_r <= done_nxt;
        end
    end

    assign mem_req = mem_r;
    assign wb      = wb_r;
    assign done    = done_r;
    assign busy    = (st_r != S_OPC);

endmodule

// ---- sim/lau_unit_sva.sv ----
/*
 * Concurrent checks of the logical-AND unit, bound to its top module.
 * Assumes the operand bytes of one instruction arrive on back-to-back edges.
 */
module lau_unit_chk (
    // Clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    // Fetch stream
    input lau_pkg::lau_byte_t fetch_in,
    input wire logic          fetch_ready,
    input wire logic          is_ours,
    // Core state
    input wire logic [7:0]    accumulator_reg,
    input wire logic          carry_flag,
    input wire logic [1:0]    bank_sel,
    // Data memory
    input lau_pkg::lau_mem_t  mem_req,
    input wire logic [7:0]    mem_rdata,
    // Write back and completion
    input lau_pkg::lau_wb_t   wb,
    input wire logic          busy,
    input wire logic          done
);
    // ----------------------------------------------------------------
    // Instruction tracking
    // ----------------------------------------------------------------
    logic       take;
    logic [7:0] op;
    logic       bit_r, bit_nxt, byte_r, byte_nxt, dir_r, dir_nxt;
    logic [2:0] sel_r, sel_nxt;

    // Operand bytes come while busy, so only an idle take is an opcode
    assign op   = fetch_in.data;
    assign take = fetch_in.valid && fetch_ready && !busy;

    always_comb begin
        bit_nxt  = bit_r && !done;
        byte_nxt = byte_r && !done;
        dir_nxt  = dir_r && !done;
        sel_nxt  = sel_r;
        if (take) begin
            bit_nxt  = (op == lau_pkg::OP_C_BIT) || (op == lau_pkg::OP_C_NBIT);
            byte_nxt = !bit_nxt;
            dir_nxt  = (op == lau_pkg::OP_DIR_A) || (op == lau_pkg::OP_DIR_IMM);
            sel_nxt  = op[2:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_r  <= 1'b0;
            byte_r <= 1'b0;
            dir_r  <= 1'b0;
            sel_r  <= 3'h0;
        end else begin
            bit_r  <= bit_nxt;
            byte_r <= byte_nxt;
            dir_r  <= dir_nxt;
            sel_r  <= sel_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_REG_READ: assert property (take && (op & lau_pkg::OP_REG_MASK) == lau_pkg::OP_REG |=>
        ##[0:6] (mem_req.rd && mem_req.addr == {3'h0, bank_sel, sel_r})) else $error("register read address wrong");
    AST_IND_PTR: assert property (take && (op & lau_pkg::OP_IND_MASK) == lau_pkg::OP_IND |=>
        ##[0:6] (mem_req.rd && mem_req.addr == {3'h0, bank_sel, 2'h0, sel_r[0]})) else $error("pointer read wrong");
    AST_ONE_CYCLE: assert property (take && op == lau_pkg::OP_A_DIR |-> ##[10:15] done)
        else $error("one-cycle form not done in time");
    AST_TWO_CYCLE: assert property (take && op == lau_pkg::OP_DIR_IMM |-> ##[20:27] done)
        else $error("three-byte form not done in time");
    AST_BIT_TWO: assert property (take && op == lau_pkg::OP_C_BIT |=> !done [*7] ##[12:19] done)
        else $error("carry form timing wrong");
    AST_CY_CLEAR: assert property (wb.cy_we && !carry_flag |-> !wb.cy)
        else $error("carry set by AND");
    AST_BIT_NO_WRITE: assert property (bit_r |-> !mem_req.wr)
        else $error("bit form wrote memory");
    AST_BIT_ONLY_CY: assert property (bit_r |-> !wb.acc_we)
        else $error("bit form wrote accumulator");
    AST_BYTE_NO_CY: assert property (byte_r |-> !wb.cy_we)
        else $error("byte form wrote carry");
    AST_DIR_LATCH: assert property (dir_r && (mem_req.rd || mem_req.wr) |-> mem_req.latch)
        else $error("direct access without latch");
    AST_DIR_SFR: assert property (dir_r && mem_req.wr |-> mem_req.sfr == mem_req.addr[7])
        else $error("special space flag wrong");

    cover property (take && op == lau_pkg::OP_DIR_IMM);
    cover property (bit_r && wb.cy_we);
    cover property (dir_r && mem_req.wr && mem_req.sfr);
endmodule

bind lau_unit lau_unit_chk u_chk (.ref_clk(ref_clk), .rst(rst), .fetch_in(fetch_in), .fetch_ready(fetch_ready),
    .is_ours(is_ours), .accumulator_reg(accumulator_reg), .carry_flag(carry_flag), .bank_sel(bank_sel),
    .mem_req(mem_req), .mem_rdata(mem_rdata), .wb(wb), .busy(busy), .done(done));

// ---- sim/lau_tb.sv ----
/*
 * Self-checking bench of the logical-AND unit with a data memory model.
 * Assumes byte 90h is a port whose latch and pin levels differ.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Signals and memory model
    // ----------------------------------------------------------------
    logic               ref_clk;
    logic               rst;
    lau_pkg::lau_byte_t fetch_in;
    logic               fetch_ready, is_ours, carry_flag, busy, done, cy_seen;
    logic [7:0]         accumulator_reg, mem_rdata, acc_seen, pin_level;
    logic [1:0]         bank_sel;
    lau_pkg::lau_mem_t  mem_req;
    lau_pkg::lau_wb_t   wb;
    logic [7:0]         ram [256];
    int                 cnt [4];
    int                 cycles = 0;
    int                 num_errors = 0;
    int                 comparisons = 0;

    lau_unit dut (.ref_clk(ref_clk), .rst(rst), .fetch_in(fetch_in), .fetch_ready(fetch_ready), .is_ours(is_ours),
        .accumulator_reg(accumulator_reg), .carry_flag(carry_flag), .bank_sel(bank_sel), .mem_req(mem_req),
        .mem_rdata(mem_rdata), .wb(wb), .busy(busy), .done(done));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Counts: bytes taken, accumulator, carry and memory writes
    always @(posedge ref_clk) begin
        if (fetch_in.valid && fetch_ready === 1'b1) cnt[0] <= cnt[0] + 1;
        if (wb.acc_we === 1'b1) begin
            cnt[1]   <= cnt[1] + 1;
            acc_seen <= wb.acc;
        end
        if (wb.cy_we === 1'b1) begin
            cnt[2]  <= cnt[2] + 1;
            cy_seen <= wb.cy;
        end
        if (mem_req.wr === 1'b1) begin
            cnt[3] <= cnt[3] + 1;
            ram[mem_req.addr] <= mem_req.wdata;
        end
        // Unread cycles show a changing value, never the last one
        if (mem_req.rd === 1'b1) mem_rdata <= (mem_req.addr == 8'h90 && !mem_req.latch) ? pin_level : ram[mem_req.addr];
        else mem_rdata <= ~mem_rdata;
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Sends opcode and n operands back to back, waits for done
    task automatic run(input logic [7:0] op, input int n, input logic [7:0] b1, input logic [7:0] b2, input int mc);
        logic [7:0] seq [3];
        time        t0;
        int         w;
        seq = '{op, b1, b2};
        t0 = 0;
        cnt = '{default: 0};
        for (int k = 0; k <= n; k++) begin
            fetch_in <= '{valid: 1'b1, data: seq[k]};
            w = 0;
            do begin
                @(posedge ref_clk);
                w++;
            end while (fetch_ready !== 1'b1 && w < 50);
            if (k == 0) begin
                check("ours on opcode", is_ours, 1);
                t0 = $time;
            end
        end
        fetch_in <= '{valid: 1'b0, data: ~seq[n]};
        w = 0;
        while (done !== 1'b1 && w < 60) begin
            @(posedge ref_clk);
            w++;
        end
        check("machine cycles", 32'((($time - t0) / 100 + 6) / 12), mc);
        repeat (2) @(posedge ref_clk);
        check("bytes taken", cnt[0], n + 1);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_foreign();
        logic [7:0] bad [3];
        bad = '{8'h00, 8'h51, 8'h83};
        for (int k = 0; k < 3; k++) begin
            fetch_in <= '{valid: 1'b1, data: bad[k]};
            @(posedge ref_clk);
            check("ready on foreign", fetch_ready, 0);
            check("ours on foreign", is_ours, 0);
        end
        fetch_in <= '{valid: 1'b0, data: 8'h7c};
        @(posedge ref_clk);
        check("busy after foreign", busy, 0);
    endtask

    task automatic t_reg();
        bank_sel <= 2'h2;
        accumulator_reg <= 8'hd7;
        for (int r = 0; r < 8; r++) begin
            run(lau_pkg::OP_REG | 8'(r), 0, 8'h00, 8'h00, 1);
            check("reg result", acc_seen, 8'hd7 & ~(8'h10 + 8'(r)));
            check("reg acc writes", cnt[1], 1);
            check("reg carry writes", cnt[2], 0);
        end
    endtask

    task automatic t_ind();
        bank_sel <= 2'h1;
        accumulator_reg <= 8'h7e;
        for (int i = 0; i < 2; i++) begin
            ram[8'h08 + i] = 8'h40 + 8'(i);
            run(lau_pkg::OP_IND | 8'(i), 0, 8'h00, 8'h00, 1);
            check("indirect result", acc_seen, 8'h7e & ~(8'h40 + 8'(i)));
            check("indirect acc writes", cnt[1], 1);
        end
    endtask

    task automatic t_acc_src();
        accumulator_reg <= 8'h3c;
        run(lau_pkg::OP_A_DIR, 1, 8'h30, 8'h00, 1);
        check("direct source result", acc_seen, 8'h0c);
        check("direct carry writes", cnt[2], 0);
        run(lau_pkg::OP_A_IMM, 1, 8'h33, 8'h00, 1);
        check("immediate result", acc_seen, 8'h30);
        check("immediate mem writes", cnt[3], 0);
    endtask

    task automatic t_dir_dest();
        accumulator_reg <= 8'ha5;
        ram[8'h30] = 8'hf0;
        run(lau_pkg::OP_DIR_A, 1, 8'h30, 8'h00, 1);
        check("ram masked by acc", ram[8'h30], 8'ha0);
        check("dir acc mem writes", cnt[3], 1);
        check("dir acc acc writes", cnt[1], 0);
        ram[8'h90] = 8'hff;
        run(lau_pkg::OP_DIR_A, 1, 8'h90, 8'h00, 1);
        check("port from latch", ram[8'h90], 8'ha5);
        ram[8'h90] = 8'hff;
        run(lau_pkg::OP_DIR_IMM, 2, 8'h90, 8'h73, 2);
        check("port masked by constant", ram[8'h90], 8'h73);
        check("dir imm mem writes", cnt[3], 1);
    endtask

    task automatic t_bit();
        logic [7:0] ba [3];
        logic [7:0] byte_a;
        logic       bv;
        ba = '{8'h0a, 8'h0b, 8'he7};
        ram[8'h21] = 8'h08;
        ram[8'he0] = 8'h80;
        for (int o = 0; o < 2; o++) begin
            for (int a = 0; a < 6; a++) begin
                byte_a = ba[a / 2][7] ? {ba[a / 2][7:3], 3'h0} : 8'h20 + 8'(ba[a / 2][6:3]);
                bv = ram[byte_a][ba[a / 2][2:0]];
                carry_flag <= a[0];
                run(o == 1 ? lau_pkg::OP_C_NBIT : lau_pkg::OP_C_BIT, 1, ba[a / 2], 8'h00, 2);
                check("carry result", cy_seen, a[0] & (o == 1 ? ~bv : bv));
                check("carry writes", cnt[2], 1);
                check("bit acc writes", cnt[1], 0);
                check("bit mem writes", cnt[3], 0);
            end
        end
    endtask

    initial begin
        rst = 1'b1;
        fetch_in = '0;
        accumulator_reg = 8'h00;
        carry_flag = 1'b0;
        bank_sel = 2'h0;
        mem_rdata = 8'h00;
        pin_level = 8'h00;
        cnt = '{default: 0};
        for (int i = 0; i < 256; i++) ram[i] = ~8'(i);
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_foreign();
        t_reg();
        t_ind();
        t_acc_src();
        t_dir_dest();
        t_bit();
        complete_run();
    end
endmodule
